// ==== hw/hsrp_pkg.sv ====
`default_nettype none
package hsrp_pkg;
  // ==========================================================
  // Framing and widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int CNT_W = 5;
  localparam logic [3:0] ADDR_BITS = 4'h8;
  localparam logic [CNT_W-1:0] LAST_BIT_1B = 5'h07;
  localparam logic [CNT_W-1:0] LAST_BIT_2B = 5'h0f;
  localparam logic [DATA_W-1:0] MASK_1B = 16'h00ff;
  localparam logic [DATA_W-1:0] MASK_2B = 16'hffff;
  localparam logic [7:0] LOW_BYTE_ZERO = 8'h00;
  // ==========================================================
  // Address map
  localparam logic [7:0] CMD_GENERAL_RESET = 8'h01;
  localparam logic [7:0] WRITE_BASE = 8'h40;
  localparam logic [7:0] READ_BASE = 8'h80;
  localparam int WIDE_BIT = 3;
  localparam logic [2:0] STREAM_CODE = 3'h7;
  // ==========================================================
  // Timing
  localparam int CORE_CLK_MHZ = 20;
  localparam int WRITE_LATENCY_US = 60;
  localparam int WRITE_LATENCY_CYCLES = WRITE_LATENCY_US * CORE_CLK_MHZ;
  localparam logic [2:0] SCLK_HALF = 3'h4;
  localparam int FIFO_DEPTH = 8;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    HSRP_CMD = 2'h0,
    HSRP_WR = 2'h1,
    HSRP_RD = 2'h2
  } hsrp_dir_t;

  function automatic hsrp_dir_t hsrp_dir(input logic [7:0] a);
    if (a >= READ_BASE) return HSRP_RD;
    if (a >= WRITE_BASE) return HSRP_WR;
    return HSRP_CMD;
  endfunction

  function automatic logic hsrp_wide(input logic [7:0] a);
    return a[WIDE_BIT];
  endfunction

  function automatic logic hsrp_streams(input logic [7:0] a);
    return (hsrp_dir(a) != HSRP_CMD) && (a[2:0] == STREAM_CODE);
  endfunction

  function automatic logic [CNT_W-1:0] hsrp_last(input logic [7:0] a);
    return hsrp_wide(a) ? LAST_BIT_2B : LAST_BIT_1B;
  endfunction

  function automatic logic [DATA_W-1:0] hsrp_mask(input logic [7:0] a);
    return hsrp_wide(a) ? MASK_2B : MASK_1B;
  endfunction

  // Left-justify a word so that its MSB goes out first
  function automatic logic [DATA_W-1:0] hsrp_align(input logic [7:0] a,
                                               input logic [DATA_W-1:0] d);
    return hsrp_wide(a) ? d : {d[7:0], LOW_BYTE_ZERO};
  endfunction
endpackage
`default_nettype wire

// ==== hw/hsrp_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface hsrp_link_if;
  logic sclk;
  logic bus_select_n;
  logic command_data_in;
  logic reply_data;
  logic reply_oe_n;
  logic host_interrupt_n;
  logic irq_oe_n;
  logic reply_wire;
  logic irq_wire;
  // ==========================================================
  // Pulled-up shared lines
  assign reply_wire = reply_oe_n ? 1'b1 : reply_data;
  assign irq_wire = irq_oe_n ? 1'b1 : host_interrupt_n;

  modport device (
    input sclk, bus_select_n, command_data_in,
    output reply_data, reply_oe_n, host_interrupt_n, irq_oe_n
  );
  modport host (
    output sclk, bus_select_n, command_data_in,
    input reply_wire, irq_wire
  );
endinterface
`default_nettype wire

// ==== hw/hsrp_device.sv ====
// Function
// - Address byte, then optional single data word
// - Streaming: one address, many words, one frame
// - Only streaming registers accept repeated words
// - Word is whole bytes, width per register
// - Address-only commands; code 01 is reset
// - Single-byte registers move first eight bits
// - Command data sampled on shift clock rise
// - Reply bit held stable over clock high
// - Host holds select low per transaction
// - Written value reaches logic within 60 us
// - Reply line driven only during reads
// - Shift clock idle level may be either
// - Gaps between bytes allowed or not
// - Interrupt only for masked-in status
// - Host reads status after an interrupt
// - Interrupt output is open-drain, active low
`timescale 1ns/1ps
`default_nettype none
module hsrp_device
  import hsrp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  hsrp_link_if.device lk,
  output logic cmd_valid,
  output logic [ADDR_W-1:0] cmd_addr,
  output logic gen_reset,
  output logic wr_valid,
  output logic [ADDR_W-1:0] wr_addr,
  output logic [DATA_W-1:0] wr_data,
  input wire logic rd_load,
  input wire logic [DATA_W-1:0] rd_word,
  output logic rd_taken,
  output logic frame_active,
  input wire logic [7:0] irq_event,
  input wire logic [7:0] irq_mask,
  input wire logic [7:0] irq_clear,
  output logic [7:0] irq_pending
);
  // ==========================================================
  // Link domain: shift engine, cleared by a high select
  logic [ADDR_W-1:0] addr_sh;
  logic [3:0] addr_cnt;
  logic [CNT_W-1:0] bit_cnt;
  logic [DATA_W-1:0] word_sh;
  logic [DATA_W-1:0] rd_sh;
  logic frozen;
  logic [DATA_W-1:0] rd_hold;
  logic [ADDR_W-1:0] next_addr;
  logic addr_phase;
  logic word_end;
  hsrp_dir_t cur_dir;

  assign next_addr = {addr_sh[ADDR_W-2:0], lk.command_data_in};
  assign addr_phase = (addr_cnt != ADDR_BITS);
  assign cur_dir = hsrp_dir(addr_sh);
  assign word_end = (bit_cnt == hsrp_last(addr_sh));

  // Select high resets the frame whatever the clock level was
  always_ff @(posedge lk.sclk or posedge lk.bus_select_n) begin
    if (lk.bus_select_n) begin
      addr_sh <= '0;
      addr_cnt <= '0;
      bit_cnt <= '0;
      word_sh <= '0;
      rd_sh <= '0;
      frozen <= 1'b0;
    end else if (addr_phase) begin
      addr_sh <= next_addr;
      addr_cnt <= addr_cnt + 4'h1;
      bit_cnt <= '0;
      if (addr_cnt == ADDR_BITS - 4'h1) begin
        rd_sh <= hsrp_align(next_addr, rd_hold);
      end
    end else if (!frozen) begin
      unique case (cur_dir)
        HSRP_WR: begin
          word_sh <= {word_sh[DATA_W-2:0], lk.command_data_in};
          bit_cnt <= word_end ? '0 : bit_cnt + 5'h01;
          if (word_end) begin
            frozen <= !hsrp_streams(addr_sh);
          end
        end
        HSRP_RD: begin
          bit_cnt <= word_end ? '0 : bit_cnt + 5'h01;
          if (word_end) begin
            rd_sh <= hsrp_align(addr_sh, rd_hold);
            frozen <= !hsrp_streams(addr_sh);
          end else begin
            rd_sh <= {rd_sh[DATA_W-2:0], 1'b0};
          end
        end
        HSRP_CMD: begin
          frozen <= 1'b1;
        end
      endcase
    end
  end

  // Reply changes on the falling edge only, and is released when select goes high
  always_ff @(negedge lk.sclk or posedge lk.bus_select_n) begin
    if (lk.bus_select_n) begin
      lk.reply_data <= 1'b0;
      lk.reply_oe_n <= 1'b1;
    end else begin
      lk.reply_data <= rd_sh[DATA_W-1];
      lk.reply_oe_n <= !(!addr_phase && cur_dir == HSRP_RD &&
                         !frozen);
    end
  end

  // ==========================================================
  // Link events, published by toggle with held payload
  logic evt_tog;
  hsrp_dir_t evt_kind;
  logic [ADDR_W-1:0] evt_addr;
  logic [DATA_W-1:0] evt_data;

  always_ff @(posedge lk.sclk or posedge rst) begin
    if (rst) begin
      evt_tog <= 1'b0;
      evt_kind <= HSRP_CMD;
      evt_addr <= '0;
      evt_data <= '0;
    end else if (!lk.bus_select_n) begin
      // Reads report here too: the first word has left the holding word
      if (addr_cnt == ADDR_BITS - 4'h1 &&
          hsrp_dir(next_addr) != HSRP_WR) begin
        evt_tog <= !evt_tog;
        evt_kind <= hsrp_dir(next_addr);
        evt_addr <= next_addr;
      end else if (!addr_phase && !frozen && word_end &&
                   cur_dir != HSRP_CMD) begin
        evt_tog <= !evt_tog;
        evt_kind <= cur_dir;
        evt_addr <= addr_sh;
        evt_data <= {word_sh[DATA_W-2:0], lk.command_data_in} &
                    hsrp_mask(addr_sh);
      end
    end
  end

  // ==========================================================
  // Core domain crossings
  logic [2:0] tog_sync;
  logic tog_seen;
  logic [2:0] sel_sync;
  logic evt_fire;

  assign evt_fire = (tog_sync[1] == tog_sync[2]) && (tog_sync[2] != tog_seen);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tog_sync <= '0;
      tog_seen <= 1'b0;
      sel_sync <= 3'h7;
      frame_active <= 1'b0;
    end else begin
      tog_sync <= {tog_sync[1:0], evt_tog};
      sel_sync <= {sel_sync[1:0], lk.bus_select_n};
      if (evt_fire) begin
        tog_seen <= tog_sync[2];
      end
      if (sel_sync[1] == sel_sync[2]) begin
        frame_active <= !sel_sync[2];
      end
    end
  end

  // Written words leave a few core cycles after their last bit
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cmd_valid <= 1'b0;
      cmd_addr <= '0;
      gen_reset <= 1'b0;
      wr_valid <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
      rd_taken <= 1'b0;
    end else begin
      cmd_valid <= evt_fire && evt_kind == HSRP_CMD;
      gen_reset <= evt_fire && evt_kind == HSRP_CMD &&
                   evt_addr == CMD_GENERAL_RESET;
      wr_valid <= evt_fire && evt_kind == HSRP_WR;
      rd_taken <= evt_fire && evt_kind == HSRP_RD;
      if (evt_fire && evt_kind == HSRP_CMD) begin
        cmd_addr <= evt_addr;
      end
      if (evt_fire && evt_kind == HSRP_WR) begin
        wr_addr <= evt_addr;
        wr_data <= evt_data;
      end
    end
  end

  // Read word is quasi-static: reload only after rd_taken or idle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_hold <= '0;
    end else if (rd_load) begin
      rd_hold <= rd_word;
    end
  end

  // ==========================================================
  // Interrupt: sticky status, set wins over clear
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_pending <= '0;
      lk.host_interrupt_n <= 1'b0;
      lk.irq_oe_n <= 1'b1;
    end else begin
      irq_pending <= (irq_pending & ~irq_clear) | irq_event;
      lk.host_interrupt_n <= 1'b0;
      lk.irq_oe_n <= !(|(irq_pending & irq_mask));
    end
  end
endmodule // hsrp_device
`default_nettype wire

// ==== hw/hsrp_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module hsrp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] count;
  logic push;
  logic pop;
  logic [AW:0] next_count;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rp];
  assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wp <= '0;
      rp <= '0;
      count <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      wp <= push ? AW'((32'(wp) + 1) % DEPTH) : wp;
      rp <= pop ? AW'((32'(rp) + 1) % DEPTH) : rp;
      count <= next_count;
      in_ready <= next_count != (AW+1)'(DEPTH);
      out_valid <= next_count != '0;
    end
  end
endmodule // hsrp_fifo

module hsrp_host
  import hsrp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  hsrp_link_if.host lk,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [7:0] req_words,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [DATA_W-1:0] tx_data,
  output logic rx_valid,
  output logic [DATA_W-1:0] rx_data,
  output logic irq_active
);
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_LEAD = 5'b00010,
    ST_SHIFT = 5'b00100,
    ST_WAIT = 5'b01000,
    ST_TRAIL = 5'b10000
  } hsrp_state_t;

  hsrp_state_t state;
  logic [2:0] ph;
  logic [DATA_W-1:0] sh;
  logic [DATA_W-1:0] rx_sh;
  logic [CNT_W-1:0] bit_cnt;
  logic [7:0] words;
  logic [ADDR_W-1:0] addr;
  logic data_phase;
  logic f_valid;
  logic [DATA_W-1:0] f_data;
  logic pop;
  logic [2:0] rep_sync;
  logic [2:0] irq_sync;
  logic rep_level;
  logic bit_end;
  logic unit_end;
  logic need_word;
  logic [DATA_W-1:0] f_aligned;

  hsrp_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data(tx_data),
    .out_valid(f_valid),
    .out_ready(pop),
    .out_data(f_data)
  );

  assign bit_end = state == ST_SHIFT && ph == SCLK_HALF + SCLK_HALF - 3'h1;
  assign unit_end = bit_end && bit_cnt == '0;
  // Next unit is a write word when words remain after the unit now ending
  assign need_word = hsrp_dir(addr) == HSRP_WR &&
                     (data_phase ? words > 8'h01 : words != 8'h00);
  assign pop = f_valid && ((state == ST_WAIT) || (unit_end && need_word));
  assign f_aligned = hsrp_align(addr, f_data);

  // ==========================================================
  // Pin inputs: three stages, level once stages two and three agree
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rep_sync <= 3'h7;
      irq_sync <= 3'h7;
      rep_level <= 1'b1;
      irq_active <= 1'b0;
    end else begin
      rep_sync <= {rep_sync[1:0], lk.reply_wire};
      irq_sync <= {irq_sync[1:0], lk.irq_wire};
      if (rep_sync[1] == rep_sync[2]) begin
        rep_level <= rep_sync[2];
      end
      if (irq_sync[1] == irq_sync[2]) begin
        irq_active <= !irq_sync[2];
      end
    end
  end

  // ==========================================================
  // Shift engine, clock idles low, one bit per 2*SCLK_HALF cycles
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= ST_IDLE;
      ph <= '0;
      sh <= '0;
      rx_sh <= '0;
      bit_cnt <= '0;
      words <= '0;
      addr <= '0;
      data_phase <= 1'b0;
      req_ready <= 1'b1;
      rx_valid <= 1'b0;
      rx_data <= '0;
      lk.sclk <= 1'b0;
      lk.bus_select_n <= 1'b1;
      lk.command_data_in <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          if (req_valid && req_ready) begin
            addr <= req_addr;
            // Non-streaming registers carry one word, commands none
            words <= hsrp_dir(req_addr) == HSRP_CMD ? 8'h00 :
                     hsrp_streams(req_addr) ? req_words : 8'h01;
            sh <= {req_addr, LOW_BYTE_ZERO};
            lk.command_data_in <= req_addr[ADDR_W-1];
            bit_cnt <= CNT_W'(ADDR_BITS - 4'h1);
            data_phase <= 1'b0;
            req_ready <= 1'b0;
            lk.bus_select_n <= 1'b0;
            ph <= '0;
            state <= ST_LEAD;
          end
        end
        ST_LEAD: begin
          ph <= ph + 3'h1;
          if (ph == SCLK_HALF - 3'h1) begin
            ph <= '0;
            state <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          ph <= bit_end ? '0 : ph + 3'h1;
          if (ph == SCLK_HALF - 3'h1) begin
            lk.sclk <= 1'b1;
          end
          if (bit_end) begin
            lk.sclk <= 1'b0;
            rx_sh <= {rx_sh[DATA_W-2:0], rep_level};
            bit_cnt <= bit_cnt - 5'h01;
            sh <= {sh[DATA_W-2:0], 1'b0};
            lk.command_data_in <= sh[DATA_W-2];
            if (unit_end) begin
              if (data_phase && hsrp_dir(addr) == HSRP_RD) begin
                rx_valid <= 1'b1;
                rx_data <= {rx_sh[DATA_W-2:0], rep_level} & hsrp_mask(addr);
              end
              if (data_phase) begin
                words <= words - 8'h01;
              end
              data_phase <= 1'b1;
              bit_cnt <= hsrp_last(addr);
              if (data_phase ? words <= 8'h01 : words == 8'h00) begin
                state <= ST_TRAIL;
              end else if (need_word && f_valid) begin
                sh <= f_aligned;
                lk.command_data_in <= f_aligned[DATA_W-1];
              end else if (need_word) begin
                state <= ST_WAIT;
              end
            end
          end
        end
        ST_WAIT: begin
          // Clock parks low until the next word is queued
          if (f_valid) begin
            sh <= f_aligned;
            lk.command_data_in <= f_aligned[DATA_W-1];
            ph <= '0;
            state <= ST_SHIFT;
          end
        end
        ST_TRAIL: begin
          ph <= ph + 3'h1;
          if (ph == SCLK_HALF - 3'h1) begin
            lk.bus_select_n <= 1'b1;
          end
          if (ph == SCLK_HALF + SCLK_HALF - 3'h1) begin
            ph <= '0;
            req_ready <= 1'b1;
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end
endmodule // hsrp_host
`default_nettype wire

// ==== tb/hsrp_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module hsrp_sva
  import hsrp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic bus_select_n,
  input wire logic command_data_in,
  input wire logic reply_data,
  input wire logic reply_oe_n,
  input wire logic host_interrupt_n,
  input wire logic irq_oe_n,
  input wire logic reply_wire,
  input wire logic irq_wire
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // ============================================================
  // Bit count in the frame and captured address
  logic sclk_q;
  logic [7:0] bits;
  logic [7:0] addr;
  logic [7:0] exp_bits;
  logic rise;
  assign rise = sclk && !sclk_q;
  assign exp_bits = (addr < WRITE_BASE) ? 8'h08 :
                    (addr[WIDE_BIT] ? 8'h18 : 8'h10);
  always_ff @(posedge core_clk) sclk_q <= rst ? 1'b0 : sclk;
  always_ff @(posedge core_clk) begin
    if (rst || bus_select_n) bits <= 8'h00;
    else if (rise) bits <= bits + 8'h01;
  end
  always_ff @(posedge core_clk) begin
    if (rst) addr <= 8'h00;
    else if (!bus_select_n && rise && bits < 8'h08)
      addr <= {addr[6:0], command_data_in};
  end
  // ============================================================
  // Properties
  property p_addr_hiz;
    bits < 8'h08 |-> reply_oe_n;
  endproperty
  a_addr_hiz: assert property (p_addr_hiz)
    else $error("reply driven outside read data");
  property p_wr_hiz;
    bits >= 8'h08 && !addr[7] |-> reply_oe_n;
  endproperty
  a_wr_hiz: assert property (p_wr_hiz)
    else $error("reply driven in a write or command");
  property p_rd_drive;
    bits == 8'h09 && addr[7] |-> !reply_oe_n;
  endproperty
  a_rd_drive: assert property (p_rd_drive)
    else $error("reply not driven in read data");
  property p_rd_stable;
    !reply_oe_n && sclk && sclk_q |-> $stable(reply_data);
  endproperty
  a_rd_stable: assert property (p_rd_stable)
    else $error("reply bit moved while clock high");
  property p_sclk_idle;
    bus_select_n && $past(bus_select_n) |-> $stable(sclk);
  endproperty
  a_sclk_idle: assert property (p_sclk_idle)
    else $error("shift clock moved outside a frame");
  property p_command_data_in_hold;
    sclk && sclk_q |-> $stable(command_data_in);
  endproperty
  a_command_data_in_hold: assert property (p_command_data_in_hold)
    else $error("command data moved while clock high");
  property p_frame_len;
    $rose(bus_select_n) && (addr < WRITE_BASE || addr[2:0] != STREAM_CODE)
      |-> bits == exp_bits;
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("frame length wrong for register");
  property p_frame_bytes;
    $rose(bus_select_n) |-> bits[2:0] == 3'h0 && bits != 8'h00;
  endproperty
  a_frame_bytes: assert property (p_frame_bytes)
    else $error("frame not whole bytes");
  property p_irq_od;
    !irq_oe_n |-> !host_interrupt_n && !irq_wire;
  endproperty
  a_irq_od: assert property (p_irq_od)
    else $error("interrupt line not pulled low");
  c_read: cover property ($rose(bus_select_n) && addr[7]);
  c_write: cover property ($rose(bus_select_n) && addr[6] && !addr[7]);
  c_stream: cover property ($rose(bus_select_n) && bits > 8'h18);
  c_irq: cover property (!irq_oe_n);
endmodule // hsrp_sva
`default_nettype wire

// ==== tb/host_serial_register_port_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module host_serial_register_port_tb
  import hsrp_pkg::*;
();
  logic core_clk, rst, req_valid, tx_valid, rd_load, req_ready, tx_ready;
  logic rx_valid, irq_active, cmd_valid, gen_reset, wr_valid, rd_taken;
  logic rd_kick, frame_active;
  logic [7:0] req_addr, req_words, cmd_addr, wr_addr, a;
  logic [7:0] irq_event, irq_mask, irq_clear, irq_pending;
  logic [DATA_W-1:0] tx_data, rx_data, wr_data, rd_word, d;
  logic [23:0] got_q[$], exp_q[$];
  logic [15:0] rd_q[$];
  logic [31:0] seed = 32'hc142d649;
  int error_cnt, n_tests, i;
  hsrp_link_if lk();
  hsrp_host u_hsrp_host (.core_clk, .rst, .lk(lk), .req_valid, .req_ready,
    .req_addr, .req_words, .tx_valid, .tx_ready, .tx_data, .rx_valid,
    .rx_data, .irq_active);
  hsrp_device u_hsrp_device (.core_clk, .rst, .lk(lk), .cmd_valid, .cmd_addr,
    .gen_reset, .wr_valid, .wr_addr, .wr_data, .rd_load, .rd_word, .rd_taken,
    .frame_active, .irq_event, .irq_mask, .irq_clear, .irq_pending);
  hsrp_sva u_hsrp_sva (.core_clk, .rst, .sclk(lk.sclk),
    .bus_select_n(lk.bus_select_n), .command_data_in(lk.command_data_in),
    .reply_data(lk.reply_data), .reply_oe_n(lk.reply_oe_n),
    .host_interrupt_n(lk.host_interrupt_n), .irq_oe_n(lk.irq_oe_n),
    .reply_wire(lk.reply_wire), .irq_wire(lk.irq_wire));
  // ============================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [15:0] msk(input logic [7:0] x);
    return x[WIDE_BIT] ? MASK_2B : MASK_1B;
  endfunction
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (wr_valid === 1'b1) got_q.push_back({wr_addr, wr_data});
    if (rx_valid === 1'b1) got_q.push_back({8'h00, rx_data});
    if (cmd_valid === 1'b1) got_q.push_back({cmd_addr, 15'h0000, gen_reset});
  end
  // Feeds the read holding word ahead of each word shifted out
  always @(posedge core_clk) begin
    rd_load <= 1'b0;
    if (rst) begin
      rd_word <= '0;
    end else if ((rd_kick || rd_taken === 1'b1) && rd_q.size() > 0) begin
      rd_load <= 1'b1;
      rd_word <= rd_q.pop_front();
    end
  end
  task automatic chk(input string nm, input logic [23:0] e,
                     input logic [23:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp(input string nm);
    chk({nm, " count"}, 24'(exp_q.size()), 24'(got_q.size()));
    while (exp_q.size() > 0 && got_q.size() > 0)
      chk(nm, exp_q.pop_front(), got_q.pop_front());
    exp_q.delete();
    got_q.delete();
    $display("%s done, mismatches so far %0d", nm, error_cnt);
  endtask
  task automatic push(input logic [15:0] w);
    int k;
    @(posedge core_clk);
    tx_valid <= 1'b1;
    tx_data <= w;
    k = 0;
    do begin @(negedge core_clk); k++; end
    while (tx_ready !== 1'b1 && k < 9000);
    chk("tx ready", 24'h1, {23'h0, tx_ready});
    @(posedge core_clk);
    tx_valid <= 1'b0;
  endtask
  task automatic xfer(input logic [7:0] x, input logic [7:0] n);
    int k;
    @(posedge core_clk);
    req_valid <= 1'b1;
    req_addr <= x;
    req_words <= n;
    k = 0;
    do begin @(negedge core_clk); k++; end
    while (req_ready !== 1'b1 && k < 99);
    chk("req accept", 24'h1, {23'h0, req_ready});
    @(posedge core_clk);
    req_valid <= 1'b0;
    k = 0;
    do begin @(negedge core_clk); k++; end
    while (req_ready !== 1'b1 && k < 9000);
    chk("req done", 24'h1, {23'h0, req_ready});
    repeat (12) @(posedge core_clk);
  endtask
  task automatic op(input logic [7:0] x, input int n);
    int j;
    for (j = 0; j < n; j++) begin
      d = 16'(rnd());
      if (x >= READ_BASE) rd_q.push_back(d);
      else push(d);
      exp_q.push_back({(x >= READ_BASE) ? 8'h00 : x, d & msk(x)});
    end
    if (x < WRITE_BASE)
      exp_q.push_back({x, 15'h0000, x == CMD_GENERAL_RESET});
    @(posedge core_clk);
    rd_kick <= 1'b1;
    @(posedge core_clk);
    rd_kick <= 1'b0;
    xfer(x, 8'(n));
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge core_clk);
    error_cnt++;
    $display("ERROR watchdog expected done seen hang");
    summarize();
  end
  // ============================================================
  // Scenarios
  initial begin
    rst = 1'b1;
    {req_valid, tx_valid, rd_kick} = 3'h0;
    {req_addr, req_words, irq_event, irq_mask, irq_clear} = 40'h0;
    tx_data = '0;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    op(CMD_GENERAL_RESET, 0);
    op(8'h3f, 0);
    op(8'h00, 0);
    cmp("command");
    for (i = 0; i < 16; i++) begin
      d = 16'(rnd());
      a = i[0] ? {1'b1, d[6:0]} : {2'b01, d[5:0]};
      if (i < 4) a = (i == 0) ? 8'h40 : (i == 1) ? 8'hfe : (i == 2) ? 8'h7e : 8'h80;
      if (a[2:0] == STREAM_CODE) a[0] = 1'b0;
      op(a, 1);
    end
    cmp("single");
    op(8'h8f, 5);
    op(8'h87, 3);
    op(8'h47, 4);
    cmp("stream");
    for (i = 0; i < 8; i++) begin
      d = 16'(rnd());
      push(d);
      exp_q.push_back({8'h4f, d});
    end
    repeat (2) @(negedge core_clk);
    chk("fifo full", 24'h0, {23'h0, tx_ready});
    exp_q.push_back({8'h4f, 16'ha55a});
    exp_q.push_back({8'h4f, 16'h5aa5});
    fork
      xfer(8'h4f, 8'h0a);
      begin
        repeat (1500) @(posedge core_clk);
        @(negedge core_clk);
        chk("frame active", 24'h1, {23'h0, frame_active});
        push(16'ha55a);
        push(16'h5aa5);
      end
    join
    @(negedge core_clk);
    chk("frame idle", 24'h0, {23'h0, frame_active});
    cmp("stall");
    @(posedge core_clk);
    irq_event <= 8'h04;
    @(posedge core_clk);
    irq_event <= 8'h00;
    repeat (10) @(negedge core_clk);
    chk("irq masked", 24'h040000, {irq_pending, 15'h0, irq_active});
    @(posedge core_clk);
    irq_mask <= 8'h04;
    repeat (10) @(negedge core_clk);
    chk("irq raised", 24'h040001, {irq_pending, 15'h0, irq_active});
    chk("irq wire", 24'h0, {23'h0, lk.irq_wire});
    @(posedge core_clk);
    irq_clear <= 8'h04;
    @(posedge core_clk);
    irq_clear <= 8'h00;
    repeat (10) @(negedge core_clk);
    chk("irq cleared", 24'h000000, {irq_pending, 15'h0, irq_active});
    chk("irq released", 24'h1, {23'h0, lk.irq_wire});
    $display("interrupt done, mismatches so far %0d", error_cnt);
    summarize();
  end
endmodule // host_serial_register_port_tb
`default_nettype wire
